/* File: hdl/bss_pkg.sv */
// shared constants, types and register map of the block string sequencer
package bss_pkg;

	// -----------------------------------------------------------------
	// widths
	// -----------------------------------------------------------------
	localparam int unsigned ADDR_W    = 24;
	localparam int unsigned BYTE_W    = 8;
	localparam int unsigned FIFO_D    = 4;

	// -----------------------------------------------------------------
	// register byte offsets on the bus
	// -----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_SRC      = 8'h08;
	localparam logic [7:0] OFS_DST      = 8'h0c;
	localparam logic [7:0] OFS_COUNT    = 8'h10;
	localparam logic [7:0] OFS_ACC      = 8'h14;
	localparam logic [7:0] OFS_SAVE_PTR = 8'h18;
	localparam logic [7:0] OFS_SAVE_CNT = 8'h1c;

	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int unsigned CTRL_START  = 0;
	localparam int unsigned CTRL_OP_LO  = 1;
	localparam int unsigned CTRL_DOWN   = 3;
	localparam int unsigned STAT_BUSY   = 0;
	localparam int unsigned STAT_SUSP_I = 1;
	localparam int unsigned STAT_SUSP_M = 2;
	localparam int unsigned STAT_FLAGS  = 8;

	// -----------------------------------------------------------------
	// reset values
	// -----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] PTR_RST   = 24'h00_0000;
	localparam logic [BYTE_W-1:0] BYTE_RST  = 8'h00;
	localparam logic [31:0]       WORD_ZERO = 32'h0000_0000;

	// -----------------------------------------------------------------
	// types
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		block_copy_op     = 2'h0,
		block_swap_op     = 2'h1,
		search_equal_op   = 2'h2,
		search_unequal_op = 2'h3
	} bss_op_t;

	typedef struct packed {
		logic sign;
		logic zero;
		logic nibble_borrow_flag;
		logic overflow;
		logic borrow_flag;
	} bss_flags_t;

	typedef struct packed {
		logic              we;
		logic [ADDR_W-1:0] addr;
		logic [BYTE_W-1:0] wdata;
	} bss_mem_cmd_t;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'h0,
		ST_RD_A   = 4'h1,
		ST_GET_A  = 4'h2,
		ST_RD_B   = 4'h3,
		ST_GET_B  = 4'h4,
		ST_WR_A   = 4'h5,
		ST_WR_B   = 4'h6,
		ST_STEP   = 4'h7,
		ST_SUSP_I = 4'h8,
		ST_SUSP_M = 4'h9
	} bss_state_t;

endpackage

/* File: hdl/bss_sequencer.sv */
// read-data fifo and the block string sequencer top with its bus slave

// -----------------------------------------------------------------
// fifo
// -----------------------------------------------------------------
module bss_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      cnt_reg;
	logic [AW:0]      cnt_next;
	logic             push;
	logic             pop;

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem_reg[rd_ptr_reg];

	always_comb begin
		cnt_next = cnt_reg;
		if (push && !pop)
			cnt_next = cnt_reg + 1'b1;
		else if (pop && !push)
			cnt_next = cnt_reg - 1'b1;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg    <= '0;
			in_ready   <= 1'b1;
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			cnt_reg  <= cnt_next;
			// registered full flag so the source sees back-pressure
			in_ready <= (cnt_next != (AW+1)'(DEPTH));
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end
endmodule // bss_fifo

module bss_sequencer (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rstn,
	// ahb-lite slave
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output logic [31:0]                      hrdata,
	output logic                             hreadyout,
	output logic                             hresp,
	// data memory bus
	output logic                             mem_req,
	output bss_pkg::bss_mem_cmd_t            mem_cmd,
	input  wire logic                        mem_ack,
	input  wire logic                        mem_rvalid,
	input  wire logic [bss_pkg::BYTE_W-1:0]  mem_rdata,
	output logic                             mem_rready,
	// interrupt and macro service
	input  wire logic                        irq_req,
	input  wire logic                        irq_return,
	input  wire logic                        ms_req,
	input  wire logic                        ms_done,
	output logic                             irq_ack,
	output logic                             ms_ack,
	// status
	output logic                             busy
);
	import bss_pkg::*;

	// -----------------------------------------------------------------
	// arithmetic
	// -----------------------------------------------------------------
	function automatic bss_flags_t sub_flags(input logic [7:0] m, input logic [7:0] a);
		logic [8:0] d;
		logic       b6;
		bss_flags_t f;
		d  = {1'b0, m} - {1'b0, a};
		b6 = (m[6:0] < a[6:0]);
		f.sign               = d[7];
		f.zero               = (d[7:0] == 8'h00);
		f.nibble_borrow_flag = (m[3:0] < a[3:0]);
		f.overflow           = b6 ^ d[8];
		f.borrow_flag        = d[8];
		return f;
	endfunction

	// copy and swap fetch the source first, compares only the destination
	function automatic bss_state_t fetch_state(input bss_op_t op);
		return (op == block_copy_op || op == block_swap_op) ? ST_RD_A : ST_RD_B;
	endfunction

	function automatic logic [ADDR_W-1:0] step_ptr(input logic [ADDR_W-1:0] p,
		input logic down);
		return down ? p - 1'b1 : p + 1'b1;
	endfunction

	// -----------------------------------------------------------------
	// declarations
	// -----------------------------------------------------------------
	bss_state_t         state_reg;
	bss_op_t            op_reg;
	logic               down_reg;
	logic [ADDR_W-1:0]  src_reg;
	logic [ADDR_W-1:0]  dst_reg;
	logic [BYTE_W-1:0]  count_reg;
	logic [BYTE_W-1:0]  acc_reg;
	logic [ADDR_W-1:0]  pointer_save_pair;
	logic [BYTE_W-1:0]  count_save_reg;
	logic [BYTE_W-1:0]  byte_a_reg;
	logic [BYTE_W-1:0]  byte_b_reg;
	bss_flags_t         flags_reg;
	bss_flags_t         cmp_flags;
	logic               wr_pend_reg;
	logic [7:0]         wr_addr_reg;
	logic               rd_req;
	logic               start;
	logic               last_iter;
	logic               is_cmp;
	logic [BYTE_W-1:0]  count_dec;
	logic               fifo_valid;
	logic               fifo_ready;
	logic [BYTE_W-1:0]  fifo_data;
	logic [31:0]        rd_word;

	assign is_cmp    = (op_reg == search_equal_op) || (op_reg == search_unequal_op);
	assign count_dec = count_reg - 1'b1;
	assign cmp_flags = sub_flags(byte_b_reg, acc_reg);

	// count is decremented before the zero test, so zero at start wraps
	always_comb begin
		last_iter = (count_dec == 8'h00);
		if (op_reg == search_equal_op && !cmp_flags.zero)
			last_iter = 1'b1;
		if (op_reg == search_unequal_op && cmp_flags.zero)
			last_iter = 1'b1;
	end

	// -----------------------------------------------------------------
	// read data buffer
	// -----------------------------------------------------------------
	assign fifo_ready = (state_reg == ST_GET_A) || (state_reg == ST_GET_B);

	bss_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_D)
	) u_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (mem_rvalid),
		.in_ready  (mem_rready),
		.in_data   (mem_rdata),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready),
		.out_data  (fifo_data)
	);

	// -----------------------------------------------------------------
	// bus slave
	// -----------------------------------------------------------------
	assign rd_req = hsel && hready && htrans[1] && !hwrite;
	assign start  = wr_pend_reg && (wr_addr_reg == OFS_CTRL) && hwdata[CTRL_START]
		&& (state_reg == ST_IDLE);

	always_comb begin
		rd_word = WORD_ZERO;
		if (haddr[7:0] == OFS_CTRL)
			rd_word = 32'({down_reg, op_reg, 1'b0});
		else if (haddr[7:0] == OFS_STATUS)
			rd_word = 32'({flags_reg, 5'h00, state_reg == ST_SUSP_M,
				state_reg == ST_SUSP_I, busy});
		else if (haddr[7:0] == OFS_SRC)
			rd_word = 32'(src_reg);
		else if (haddr[7:0] == OFS_DST)
			rd_word = 32'(dst_reg);
		else if (haddr[7:0] == OFS_COUNT)
			rd_word = 32'(count_reg);
		else if (haddr[7:0] == OFS_ACC)
			rd_word = 32'(acc_reg);
		else if (haddr[7:0] == OFS_SAVE_PTR)
			rd_word = 32'(pointer_save_pair);
		else if (haddr[7:0] == OFS_SAVE_CNT)
			rd_word = 32'(count_save_reg);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hrdata      <= WORD_ZERO;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			wr_pend_reg <= hsel && hready && htrans[1] && hwrite;
			if (hsel && hready && htrans[1])
				wr_addr_reg <= {haddr[7:2], 2'b00};
			if (rd_req)
				hrdata <= rd_word;
		end
	end

	// -----------------------------------------------------------------
	// working registers
	// -----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			op_reg            <= block_copy_op;
			down_reg          <= 1'b0;
			src_reg           <= PTR_RST;
			dst_reg           <= PTR_RST;
			count_reg         <= BYTE_RST;
			acc_reg           <= BYTE_RST;
			pointer_save_pair <= PTR_RST;
			count_save_reg    <= BYTE_RST;
		end else begin
			// bus writes reach the working set only while idle
			if (wr_pend_reg && state_reg == ST_IDLE) begin
				if (wr_addr_reg == OFS_CTRL) begin
					op_reg   <= bss_op_t'(hwdata[CTRL_OP_LO +: 2]);
					down_reg <= hwdata[CTRL_DOWN];
				end else if (wr_addr_reg == OFS_SRC)
					src_reg <= hwdata[ADDR_W-1:0];
				else if (wr_addr_reg == OFS_DST)
					dst_reg <= hwdata[ADDR_W-1:0];
				else if (wr_addr_reg == OFS_COUNT)
					count_reg <= hwdata[BYTE_W-1:0];
				else if (wr_addr_reg == OFS_ACC)
					acc_reg <= hwdata[BYTE_W-1:0];
			end
			// the handler may edit the saved context while suspended in ST_SUSP_I, not in ST_SUSP_M
			if (wr_pend_reg && state_reg == ST_SUSP_I) begin
				if (wr_addr_reg == OFS_SAVE_PTR)
					pointer_save_pair <= hwdata[ADDR_W-1:0];
				else if (wr_addr_reg == OFS_SAVE_CNT)
					count_save_reg <= hwdata[BYTE_W-1:0];
			end
			if (state_reg == ST_STEP) begin
				dst_reg   <= step_ptr(dst_reg, down_reg);
				count_reg <= count_dec;
				if (!is_cmp)
					src_reg <= step_ptr(src_reg, down_reg);
				if (!last_iter && irq_req) begin
					pointer_save_pair <= step_ptr(dst_reg, down_reg);
					count_save_reg    <= count_dec;
				end
			end
			if (state_reg == ST_SUSP_I && irq_return) begin
				dst_reg   <= pointer_save_pair;
				count_reg <= count_save_reg;
			end
		end
	end

	// -----------------------------------------------------------------
	// flags
	// -----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flags_reg <= '0;
		end else if (state_reg == ST_STEP && is_cmp) begin
			// copy and swap never reach this update
			flags_reg <= cmp_flags;
		end
	end

	// -----------------------------------------------------------------
	// sequencer and memory requests
	// -----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg  <= ST_IDLE;
			mem_req    <= 1'b0;
			mem_cmd    <= '0;
			byte_a_reg <= BYTE_RST;
			byte_b_reg <= BYTE_RST;
			irq_ack    <= 1'b0;
			ms_ack     <= 1'b0;
			busy       <= 1'b0;
		end else begin
			irq_ack <= 1'b0;
			ms_ack  <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (start) begin
						busy      <= 1'b1;
						// the op lands at this same edge, so decode it from the write
						state_reg <= fetch_state(bss_op_t'(hwdata[CTRL_OP_LO +: 2]));
					end
				end
				ST_RD_A: begin
					if (!mem_req) begin
						mem_req <= 1'b1;
						mem_cmd <= '{we: 1'b0, addr: src_reg, wdata: BYTE_RST};
					end else if (mem_ack) begin
						mem_req   <= 1'b0;
						state_reg <= ST_GET_A;
					end
				end
				ST_GET_A: begin
					if (fifo_valid) begin
						byte_a_reg <= fifo_data;
						state_reg  <= (op_reg == block_swap_op) ? ST_RD_B : ST_WR_A;
					end
				end
				ST_RD_B: begin
					if (!mem_req) begin
						mem_req <= 1'b1;
						mem_cmd <= '{we: 1'b0, addr: dst_reg, wdata: BYTE_RST};
					end else if (mem_ack) begin
						mem_req   <= 1'b0;
						state_reg <= ST_GET_B;
					end
				end
				ST_GET_B: begin
					if (fifo_valid) begin
						byte_b_reg <= fifo_data;
						// compares only read, never write
						state_reg  <= is_cmp ? ST_STEP : ST_WR_A;
					end
				end
				ST_WR_A: begin
					if (!mem_req) begin
						mem_req <= 1'b1;
						mem_cmd <= '{we: 1'b1, addr: dst_reg, wdata: byte_a_reg};
					end else if (mem_ack) begin
						mem_req   <= 1'b0;
						state_reg <= (op_reg == block_swap_op) ? ST_WR_B : ST_STEP;
					end
				end
				ST_WR_B: begin
					if (!mem_req) begin
						mem_req <= 1'b1;
						mem_cmd <= '{we: 1'b1, addr: src_reg, wdata: byte_b_reg};
					end else if (mem_ack) begin
						mem_req   <= 1'b0;
						state_reg <= ST_STEP;
					end
				end
				ST_STEP: begin
					if (last_iter) begin
						busy      <= 1'b0;
						state_reg <= ST_IDLE;
					end else if (irq_req) begin
						irq_ack   <= 1'b1;
						state_reg <= ST_SUSP_I;
					end else if (ms_req) begin
						ms_ack    <= 1'b1;
						state_reg <= ST_SUSP_M;
					end else begin
						state_reg <= fetch_state(op_reg);
					end
				end
				ST_SUSP_I: begin
					if (irq_return)
						state_reg <= fetch_state(op_reg);
				end
				ST_SUSP_M: begin
					if (ms_done)
						state_reg <= fetch_state(op_reg);
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end
endmodule // bss_sequencer

/* File: test/bss_props.sv */
// port checker of the block string sequencer
module bss_props (
	// clock and reset
	input wire logic                  clk,
	input wire logic                  rstn,
	// bus and memory
	input wire logic                  hreadyout,
	input wire logic                  hresp,
	input wire logic                  mem_req,
	input wire bss_pkg::bss_mem_cmd_t mem_cmd,
	input wire logic                  mem_ack,
	// suspension and status
	input wire logic                  irq_return,
	input wire logic                  ms_done,
	input wire logic                  irq_ack,
	input wire logic                  ms_ack,
	input wire logic                  busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	okay_zero_wait_a: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or answered an error");
	cmd_held_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
		else $error("memory request dropped or changed before ack");
	req_drop_a: assert property (mem_req && mem_ack |=> !mem_req)
		else $error("memory request held after ack");
	start_fetch_a: assert property ($rose(busy) |-> ##[1:4] mem_req)
		else $error("no memory access after start");
	idle_quiet_a: assert property (!busy |-> !mem_req && !irq_ack && !ms_ack)
		else $error("activity while idle");
	irq_hold_a: assert property (irq_ack |=> (!irq_ack && busy && !mem_req) [*4])
		else $error("interrupt suspension not held");
	ms_hold_a: assert property (ms_ack |=> (!ms_ack && busy && !mem_req) [*3])
		else $error("macro service suspension not held");
	irq_resume_a: assert property (irq_return && busy |-> ##[1:20] mem_req)
		else $error("no resume after interrupt return");
	ms_resume_a: assert property (ms_done && busy |-> ##[1:20] mem_req)
		else $error("no resume after macro service");
endmodule // bss_props

bind bss_sequencer bss_props chk_u (
	.clk(clk), .rstn(rstn), .hreadyout(hreadyout), .hresp(hresp),
	.mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack),
	.irq_return(irq_return), .ms_done(ms_done), .irq_ack(irq_ack),
	.ms_ack(ms_ack), .busy(busy)
);

/* File: test/bss_mem_model.sv */
// behavioural data memory on the far side of the sequencer
module bss_mem_model (
	// clock and reset
	input wire logic                  clk,
	input wire logic                  rstn,
	// pacing
	input wire logic                  slow,
	// memory bus
	input wire logic                  mem_req,
	input wire bss_pkg::bss_mem_cmd_t mem_cmd,
	output logic                      mem_ack,
	output logic                      mem_rvalid,
	output logic [7:0]                mem_rdata,
	input wire logic                  mem_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:4095];
	logic [7:0] rbuf;
	logic [1:0] wt;
	logic [1:0] rw;
	logic       pend;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mem_ack <= 1'b0;
			mem_rvalid <= 1'b0;
			mem_rdata <= 8'h00;
			wt <= 2'h0;
			rw <= 2'h0;
			pend <= 1'b0;
		end else begin
			mem_ack <= 1'b0;
			if (mem_req && !mem_ack) begin
				if (wt != 2'h0) wt <= wt - 2'h1;
				else begin
					mem_ack <= 1'b1;
					wt <= slow ? 2'($urandom % 4) : 2'h0;
					if (mem_cmd.we) mem[mem_cmd.addr[11:0]] <= mem_cmd.wdata;
					else begin
						rbuf <= mem[mem_cmd.addr[11:0]];
						rw <= slow ? 2'($urandom % 4) : 2'h0;
						pend <= 1'b1;
					end
				end
			end
			if (pend && !mem_rvalid && rw == 2'h0) begin
				mem_rvalid <= 1'b1;
				mem_rdata <= rbuf;
				pend <= 1'b0;
			end else if (pend && rw != 2'h0) rw <= rw - 2'h1;
			// a released data line shows the inverse, never the stale byte
			if (mem_rvalid && mem_rready) begin
				mem_rvalid <= 1'b0;
				mem_rdata <= ~mem_rdata;
			end
		end
	end
endmodule // bss_mem_model

/* File: test/testbench.sv */
// self-checking bench of the block string sequencer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import bss_pkg::*;
	logic clk, rstn, hsel, hwrite, hreadyout, hresp, slow, busy;
	logic mem_req, mem_ack, mem_rvalid, mem_rready;
	logic irq_req, irq_return, ms_req, ms_done, irq_ack, ms_ack;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] mem_rdata, c, acc, x, ec;
	logic [23:0] s, d, es, ed;
	logic dn;
	bss_op_t op;
	bss_flags_t ef;
	bss_mem_cmd_t mem_cmd;
	logic [7:0] em [0:4095];
	int fail_count, n_compared, cyc, k, it;

	bss_sequencer dut_u (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .mem_req, .mem_cmd, .mem_ack,
		.mem_rvalid, .mem_rdata, .mem_rready, .irq_req, .irq_return, .ms_req, .ms_done,
		.irq_ack, .ms_ack, .busy);
	bss_mem_model mem_u (.clk, .rstn, .slow, .mem_req, .mem_cmd, .mem_ack, .mem_rvalid,
		.mem_rdata, .mem_rready);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		$display("compared %0d mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(logic [7:0] a, logic w, logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	function automatic bss_flags_t fl(logic [7:0] m, logic [7:0] a);
		bss_flags_t f;
		logic [7:0] r;
		r = m - a;
		f.sign = r[7];
		f.zero = (r == 8'h00);
		f.nibble_borrow_flag = m[3:0] < a[3:0];
		f.borrow_flag = m < a;
		f.overflow = (m[6:0] < a[6:0]) ^ f.borrow_flag;
		return f;
	endfunction
	task automatic poke(logic [23:0] a, logic [7:0] v);
		em[a[11:0]] = v;
		mem_u.mem[a[11:0]] = v;
	endtask
	// byte-by-byte prediction, so any overlap of the two areas comes out right
	task automatic predict;
		logic [7:0] t;
		do begin
			t = em[ed[11:0]];
			if (!op[1]) em[ed[11:0]] = em[es[11:0]];
			if (op == block_swap_op) em[es[11:0]] = t;
			if (op[1]) ef = fl(t, acc);
			if (!op[1]) es = dn ? es - 24'h1 : es + 24'h1;
			ed = dn ? ed - 24'h1 : ed + 24'h1;
			ec = ec - 8'h1;
		end while (ec != 0 && !(op == search_equal_op && !ef.zero)
			&& !(op == search_unequal_op && ef.zero));
	endtask
	task automatic setup(bss_op_t o, logic w, logic [23:0] sa, logic [23:0] da,
		logic [7:0] n, int i);
		op = o;
		dn = w;
		s = sa;
		d = da;
		c = n;
		acc = 8'h00;
		it = i;
	endtask
	task automatic run;
		logic [23:0] k24;
		int n;
		bus(OFS_SRC, 1'b1, {8'h0, s});
		bus(OFS_DST, 1'b1, {8'h0, d});
		bus(OFS_COUNT, 1'b1, {24'h0, c});
		bus(OFS_ACC, 1'b1, {24'h0, acc});
		bus(OFS_CTRL, 1'b1, {28'h0, dn, op, 1'b1});
		es = s;
		ed = d;
		ec = c;
		predict();
		irq_req <= (it == 1);
		ms_req <= (it == 2);
		if (it != 0) begin
			do @(posedge clk); while (irq_ack !== 1'b1 && ms_ack !== 1'b1);
			irq_req <= 1'b0;
			ms_req <= 1'b0;
			bus(OFS_STATUS, 1'b0, 32'h0);
			cmp("suspend status", {29'h0, it == 2, it == 1, 1'b1}, rd & 32'h7);
			bus(OFS_SAVE_CNT, 1'b0, 32'h0);
			k24 = {16'h0, c - rd[7:0]};
			bus(OFS_SAVE_PTR, 1'b0, 32'h0);
			if (it == 1) cmp("saved pointer", {8'h0, dn ? d - k24 : d + k24}, rd);
			repeat (5) @(posedge clk);
			irq_return <= (it == 1);
			ms_done <= (it == 2);
			@(posedge clk);
			irq_return <= 1'b0;
			ms_done <= 1'b0;
		end
		repeat (2) @(posedge clk);
		while (busy !== 1'b0) @(posedge clk);
		bus(OFS_DST, 1'b0, 32'h0);
		cmp("destination pointer", {8'h0, ed}, rd);
		bus(OFS_SRC, 1'b0, 32'h0);
		cmp("source pointer", {8'h0, es}, rd);
		bus(OFS_COUNT, 1'b0, 32'h0);
		cmp("count", {24'h0, ec}, rd);
		bus(OFS_STATUS, 1'b0, 32'h0);
		cmp("status flags", {19'h0, ef, 8'h0}, rd);
		bus(OFS_ACC, 1'b0, 32'h0);
		cmp("accumulator", {24'h0, acc}, rd);
		n = 0;
		for (int i = 0; i < 4096; i++) if (mem_u.mem[i] !== em[i]) n++;
		cmp("memory bytes differing", 32'h0, n);
		$display("test op %0d down %0b count %0d done", op, dn, c);
	endtask

	initial begin
		rstn = 1'b0;
		{hsel, hwrite, irq_req, irq_return, ms_req, ms_done, slow} = '0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		ef = '0;
		rd = $urandom(32'h5e44bf4e);
		for (int i = 0; i < 4096; i++) poke(24'(i), 8'($urandom));
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		bus(8'h24, 1'b1, 32'hffff_ffff);
		bus(OFS_SAVE_CNT, 1'b1, 32'h5a);
		for (int a = 0; a < 40; a += 4) begin
			bus(8'(a), 1'b0, 32'h0);
			cmp("idle register", 32'h0, rd);
		end
		$display("test reset and unmapped done");
		setup(block_copy_op, 1'b0, 24'h400, 24'h402, 8'h10, 0);
		run();
		setup(block_copy_op, 1'b1, 24'h50f, 24'h50d, 8'h10, 1);
		run();
		setup(block_copy_op, 1'b0, 24'h200, 24'hc00, 8'h00, 0);
		run();
		setup(block_swap_op, 1'b1, 24'h300, 24'ha00, 8'h08, 2);
		run();
		for (int t = 0; t < 28; t++) begin
			op = bss_op_t'($urandom % 4);
			dn = 1'($urandom % 2);
			c = 8'(3 + $urandom % 22);
			s = 24'(12'h100 + $urandom % 12'h600);
			d = ($urandom % 2) ? 24'(s + $urandom % 9 - 4) : 24'(12'h900 + $urandom % 12'h500);
			acc = 8'($urandom);
			x = 8'(1 + $urandom % 255);
			k = 2 + $urandom % (c + 2);
			if (op[1]) for (int i = 0; i < c; i++)
				poke(dn ? d - 24'(i) : d + 24'(i), ((op == search_equal_op) == (i == k)) ? acc ^ x : acc);
			slow <= 1'($urandom % 2);
			it = $urandom % 4;
			if (it == 3) it = 0;
			run();
		end
		report_and_stop();
	end
endmodule // testbench
